//--- rtl/lar_regs.sv
// Bulk ack status, link control and diagnostic_test_register write gate behind AXI4-Lite
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lar_regs (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        soft_rst_i,
  // AXI4-Lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Bulk FIFO ack results from the transmitter
  input  wire logic        ack_normal_i,
  input  wire logic [3:0]  ack_code_i,
  input  wire logic        ack_timeout_i,
  input  wire logic        ack_long_i,
  input  wire logic        ack_short_i,
  // Transmitter control
  input  wire logic        tx_arb_req_i,
  output logic             tx_go_o,
  output logic             transmitter_enable_o,
  output logic             transmitter_soft_reset_o,
  // Receiver control
  output logic             self_id_receive_enable_o,
  output logic             receiver_soft_reset_o,
  input  wire logic        rx_ackable_i,
  input  wire logic        rx_write_lock_i,
  input  wire logic        rx_fifo_room_i,
  output logic             rx_ack_strobe_o,
  output logic [3:0]       rx_ack_code_o,
  // Contender pin
  input  wire logic        contender_i,
  output logic             contender_o,
  output logic             contender_oe_n_o
);
  import lar_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // State
  logic        aw_full_q, w_full_q, bvalid_q, awready_q, wready_q;
  logic        aw_full_d, w_full_d, bvalid_d;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q;
  logic        arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [4:0]  ack_code_q;
  logic        ack_valid_q;
  logic [31:0] link_control_q;
  logic        diagnostic_test_register_register_write_enable_q;
  logic        pin_q;
  logic        tx_go_q;
  logic        rx_strobe_q;
  logic [3:0]  rx_code_q;

  logic        do_write, do_read, any_rst;
  logic        wr_back, wr_link_control, wr_diagnostic_test_register, wr_hit;
  logic        rd_back, rd_hit;
  logic        ack_evt;
  logic [4:0]  ack_new;
  logic [31:0] back_word, link_control_word, diagnostic_test_register_word;
  logic [31:0] wmask;

  assign any_rst = sys_rst_i | soft_rst_i;

  //////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  assign do_write = aw_full_q & w_full_q & ~bvalid_q;

  always_comb begin
    aw_full_d = aw_full_q | (s_axi_awvalid & awready_q);
    w_full_d  = w_full_q | (s_axi_wvalid & wready_q);
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
    end
    bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bresp_q   <= LAR_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      bvalid_q  <= bvalid_d;
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      if (do_write) begin
        bresp_q <= wr_hit ? LAR_RESP_OKAY : LAR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid & awready_q) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  assign wr_back  = do_write & (awaddr_q[7:2] == LAR_BULK_ACK_OFF[7:2]);
  assign wr_link_control = do_write & (awaddr_q[7:2] == LAR_LINK_CTRL_OFF[7:2]);
  assign wr_diagnostic_test_register  = do_write & (awaddr_q[7:2] == LAR_DIAGNOSTIC_TEST_REGISTER_OFF[7:2]);
  assign wr_hit   = wr_back | wr_link_control | wr_diagnostic_test_register;

  // Byte lane mask from the strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Read channel: one word, answered the cycle after the address is taken
  assign do_read = s_axi_arvalid & arready_q;
  assign rd_back = do_read & (s_axi_araddr[7:2] == LAR_BULK_ACK_OFF[7:2]);
  assign rd_hit  = rd_back
                 | (s_axi_araddr[7:2] == LAR_LINK_CTRL_OFF[7:2])
                 | (s_axi_araddr[7:2] == LAR_DIAGNOSTIC_TEST_REGISTER_OFF[7:2]);

  always_comb begin
    back_word = 32'h0000_0000;
    back_word[LAR_ACK_CODE_LSB +: 4] = ack_code_q[3:0];
    back_word[LAR_ACK_FLAG_BIT]      = ack_code_q[4];
    back_word[LAR_ACK_VALID_BIT]     = ack_valid_q;
    link_control_word = link_control_q & LAR_LINK_CONTROL_WMASK;
    diagnostic_test_register_word  = 32'h0000_0000;
    diagnostic_test_register_word[LAR_DIAGNOSTIC_TEST_REGISTER_DIAGNOSTIC_TEST_REGISTER_REGISTER_WRITE_ENABLE_BIT] = diagnostic_test_register_register_write_enable_q;
    diagnostic_test_register_word[LAR_DIAGNOSTIC_TEST_REGISTER_PIN_BIT]   = pin_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= LAR_RESP_OKAY;
    end else begin
      if (do_read) begin
        rvalid_q  <= 1'b1;
        arready_q <= 1'b0;
        rresp_q   <= rd_hit ? LAR_RESP_OKAY : LAR_RESP_SLVERR;
        if (s_axi_araddr[7:2] == LAR_BULK_ACK_OFF[7:2]) begin
          rdata_q <= back_word;
        end else if (s_axi_araddr[7:2] == LAR_LINK_CTRL_OFF[7:2]) begin
          rdata_q <= link_control_word;
        end else if (s_axi_araddr[7:2] == LAR_DIAGNOSTIC_TEST_REGISTER_OFF[7:2]) begin
          rdata_q <= diagnostic_test_register_word;
        end else begin
          rdata_q <= 32'h0000_0000;
        end
      end else if (rvalid_q & s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end else if (~rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bulk ack status
  assign ack_evt = ack_normal_i | ack_timeout_i | ack_long_i | ack_short_i;

  // Timeout outranks a malformed ack, which outranks a normal code
  always_comb begin
    if (ack_timeout_i) begin
      ack_new = {1'b1, LAR_EXT_TIMEOUT};
    end else if (ack_long_i) begin
      ack_new = {1'b1, LAR_EXT_LONG};
    end else if (ack_short_i) begin
      ack_new = {1'b1, LAR_EXT_SHORT};
    end else begin
      ack_new = {1'b0, ack_code_i};
    end
  end

  // New ack beats a software write or a read clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      ack_code_q  <= LAR_ACK_RST;
      ack_valid_q <= 1'b0;
    end else if (ack_evt) begin
      ack_code_q  <= ack_new;
      ack_valid_q <= 1'b1;
    end else if (wr_back & diagnostic_test_register_register_write_enable_q) begin
      if (wstrb_q[2]) begin
        ack_code_q[4] <= wdata_q[LAR_ACK_FLAG_BIT];
      end
      if (wstrb_q[3]) begin
        ack_code_q[3:0] <= wdata_q[LAR_ACK_CODE_LSB +: 4];
        ack_valid_q     <= wdata_q[LAR_ACK_VALID_BIT];
      end
    end else if (rd_back) begin
      ack_valid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link control; reset bits live one cycle so each write is one pulse
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      link_control_q <= LAR_LINK_CONTROL_RST;
    end else if (wr_link_control) begin
      link_control_q <= ((link_control_q & ~wmask) | (wdata_q & wmask))
               & LAR_LINK_CONTROL_WMASK;
    end else begin
      link_control_q[LAR_TXRST_BIT] <= 1'b0;
      link_control_q[LAR_RXRST_BIT] <= 1'b0;
    end
  end

  // Diagnostic_test_register write gate and a sampled view of the contender pin
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) begin
      diagnostic_test_register_register_write_enable_q <= 1'b0;
      pin_q   <= 1'b0;
    end else begin
      pin_q <= contender_i;
      if (wr_diagnostic_test_register & wstrb_q[0]) begin
        diagnostic_test_register_register_write_enable_q <= wdata_q[LAR_DIAGNOSTIC_TEST_REGISTER_DIAGNOSTIC_TEST_REGISTER_REGISTER_WRITE_ENABLE_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmitter gate: a transmit reset also drops any grant in flight
  always_ff @(posedge ref_clk_i) begin
    if (any_rst | link_control_q[LAR_TXRST_BIT]) begin
      tx_go_q <= 1'b0;
    end else begin
      tx_go_q <= tx_arb_req_i & link_control_q[LAR_TRANSMITTER_ENABLE_BIT];
    end
  end

  // Receiver ack answer
  always_ff @(posedge ref_clk_i) begin
    if (any_rst | link_control_q[LAR_RXRST_BIT]) begin
      rx_strobe_q <= 1'b0;
      rx_code_q   <= 4'h0;
    end else begin
      rx_strobe_q <= rx_ackable_i;
      if (rx_ackable_i) begin
        if (link_control_q[LAR_BUSY_BIT]) begin
          rx_code_q <= LAR_ACK_BUSY_X;
        end else if (~rx_fifo_room_i) begin
          rx_code_q <= LAR_ACK_BUSY_X;
        end else if (rx_write_lock_i & ~link_control_q[LAR_PEND_BIT]) begin
          rx_code_q <= LAR_ACK_COMPLETE;
        end else begin
          rx_code_q <= LAR_ACK_PENDING;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign tx_go_o                  = tx_go_q;
  assign transmitter_enable_o     = link_control_q[LAR_TRANSMITTER_ENABLE_BIT];
  assign transmitter_soft_reset_o = link_control_q[LAR_TXRST_BIT];
  assign self_id_receive_enable_o = link_control_q[LAR_SELFID_BIT];
  assign receiver_soft_reset_o    = link_control_q[LAR_RXRST_BIT];
  assign rx_ack_strobe_o          = rx_strobe_q;
  assign rx_ack_code_o            = rx_code_q;
  // Enable is low while driving, so the direction bit maps straight on
  assign contender_o      = link_control_q[LAR_CTDR_VAL_BIT];
  assign contender_oe_n_o = link_control_q[LAR_CTDR_DIR_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (any_rst);

  AST_ACK_NORMAL: assert property (
    ack_normal_i && !ack_timeout_i && !ack_long_i && !ack_short_i
    |=> ack_code_q == {1'b0, $past(ack_code_i)} && ack_valid_q)
    else $error("normal ack not captured");

  AST_ACK_TIMEOUT: assert property (
    ack_timeout_i |=> ack_code_q == 5'h10 && ack_valid_q)
    else $error("timeout code wrong");

  AST_ACK_LONG: assert property (
    ack_long_i && !ack_timeout_i |=> ack_code_q == 5'h11)
    else $error("long ack code wrong");

  AST_ACK_SHORT: assert property (
    ack_short_i && !ack_timeout_i && !ack_long_i |=> ack_code_q == 5'h12)
    else $error("short ack code wrong");

  AST_VALID_READ_CLEAR: assert property (
    rd_back && !ack_evt && !wr_back |=> !ack_valid_q ##1 s_axi_rvalid
    or !ack_valid_q)
    else $error("valid flag not cleared by read");

  AST_RO_WITHOUT_DIAGNOSTIC_TEST_REGISTER: assert property (
    !diagnostic_test_register_register_write_enable_q && !ack_evt |=> $stable(ack_code_q))
    else $error("ack field changed without diagnostic_test_register gate");

  AST_RESET_VALUES: assert property (disable iff (1'b0)
    sys_rst_i |=> link_control_q == 32'h0000_2040 && ack_code_q == 5'h00
    && !ack_valid_q && !diagnostic_test_register_register_write_enable_q)
    else $error("reset values wrong");

  AST_TX_RESET_PULSE: assert property (
    link_control_q[LAR_TXRST_BIT] && !wr_link_control
    |=> !link_control_q[LAR_TXRST_BIT] && !tx_go_q)
    else $error("transmit reset did not self clear");

  AST_RX_RESET_PULSE: assert property (
    link_control_q[LAR_RXRST_BIT] && !wr_link_control
    |=> !link_control_q[LAR_RXRST_BIT] && !rx_strobe_q)
    else $error("receive reset did not self clear");

  AST_FORCED_BUSY: assert property (
    rx_ackable_i && link_control_q[LAR_BUSY_BIT] && !link_control_q[LAR_RXRST_BIT]
    |=> rx_ack_strobe_o && rx_ack_code_o == 4'h4)
    else $error("forced busy not applied");

  AST_NO_ROOM_BUSY: assert property (
    rx_ackable_i && !rx_fifo_room_i && !link_control_q[LAR_RXRST_BIT]
    |=> rx_ack_code_o == 4'h4)
    else $error("full FIFO not answered busy");

  AST_PENDING_SEL: assert property (
    rx_ackable_i && rx_write_lock_i && rx_fifo_room_i
    && !link_control_q[LAR_BUSY_BIT] && !link_control_q[LAR_RXRST_BIT]
    |=> rx_ack_code_o == ($past(link_control_q[LAR_PEND_BIT]) ? 4'h2 : 4'h1))
    else $error("write ack code wrong");

  AST_TX_GATE: assert property (
    tx_go_o |-> $past(link_control_q[LAR_TRANSMITTER_ENABLE_BIT]) && $past(tx_arb_req_i))
    else $error("transmit granted while disabled");

  AST_UNUSED_ZERO: assert property (
    (link_control_q & ~LAR_LINK_CONTROL_WMASK) == 32'h0000_0000)
    else $error("unused control bit set");

  COV_ACK_THEN_READ: cover property (ack_evt ##[1:20] rd_back);
  COV_DIAGNOSTIC_TEST_REGISTER_WRITE: cover property (wr_back && diagnostic_test_register_register_write_enable_q);
  COV_FORCED_BUSY: cover property (rx_ackable_i && link_control_q[LAR_BUSY_BIT]);
  COV_SET_BEATS_CLEAR: cover property (ack_evt && rd_back);

endmodule : lar_regs

//--- rtl/lar_pkg.sv
// Constants for the link acknowledge status and link control registers
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package lar_pkg;

  // Register byte offsets
  localparam logic [7:0]  LAR_BULK_ACK_OFF   = 8'h08;
  localparam logic [7:0]  LAR_LINK_CTRL_OFF  = 8'h0c;
  localparam logic [7:0]  LAR_DIAGNOSTIC_TEST_REGISTER_OFF       = 8'h30;

  // Bulk ack status fields
  localparam int unsigned LAR_ACK_FLAG_BIT   = 23;
  localparam int unsigned LAR_ACK_CODE_LSB   = 24;
  localparam int unsigned LAR_ACK_VALID_BIT  = 31;

  // Link control fields
  localparam int unsigned LAR_TRANSMITTER_ENABLE_BIT       = 0;
  localparam int unsigned LAR_SELFID_BIT     = 1;
  localparam int unsigned LAR_BUSY_BIT       = 2;
  localparam int unsigned LAR_CTDR_VAL_BIT   = 5;
  localparam int unsigned LAR_CTDR_DIR_BIT   = 6;
  localparam int unsigned LAR_TXRST_BIT      = 10;
  localparam int unsigned LAR_RXRST_BIT      = 11;
  localparam int unsigned LAR_PEND_BIT       = 13;
  localparam logic [31:0] LAR_LINK_CONTROL_RST      = 32'h0000_2040;
  localparam logic [31:0] LAR_LINK_CONTROL_WMASK    = 32'h0000_2c67;

  // Diagnostic fields
  localparam int unsigned LAR_DIAGNOSTIC_TEST_REGISTER_DIAGNOSTIC_TEST_REGISTER_REGISTER_WRITE_ENABLE_BIT = 0;
  localparam int unsigned LAR_DIAGNOSTIC_TEST_REGISTER_PIN_BIT   = 1;

  // Ack field values
  localparam logic [4:0]  LAR_ACK_RST        = 5'h00;
  localparam logic [3:0]  LAR_EXT_TIMEOUT    = 4'h0;
  localparam logic [3:0]  LAR_EXT_LONG       = 4'h1;
  localparam logic [3:0]  LAR_EXT_SHORT      = 4'h2;
  localparam logic [3:0]  LAR_ACK_COMPLETE   = 4'h1;
  localparam logic [3:0]  LAR_ACK_PENDING    = 4'h2;
  localparam logic [3:0]  LAR_ACK_BUSY_X     = 4'h4;

  // Bus responses
  localparam logic [1:0]  LAR_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  LAR_RESP_SLVERR    = 2'h2;

endpackage : lar_pkg

//--- bench/lar_link_model.sv
// Link-side stand-in: ack events, received packets, contender pin
`timescale 1ns/1ps
module lar_link_model (
  // Clock and pin
  input  wire logic       clk_i,
  input  wire logic       ctdr_i,
  input  wire logic       ctdr_oe_n_i,
  input  wire logic       far_ctdr_i,
  output logic            pin_o,
  // Ack results
  output logic            ack_normal_o,
  output logic            ack_timeout_o,
  output logic            ack_long_o,
  output logic            ack_short_o,
  output logic [3:0]      ack_code_o,
  // Received packets
  output logic            rx_ackable_o,
  output logic            rx_wl_o,
  output logic            rx_room_o
);
  // Pin falls back to the far node once our driver lets go
  assign pin_o = ctdr_oe_n_i ? far_ctdr_i : ctdr_i;
  initial begin
    {ack_normal_o, ack_timeout_o, ack_long_o, ack_short_o} = 4'h0;
    ack_code_o = 4'h0;
    {rx_ackable_o, rx_wl_o, rx_room_o} = 3'h0;
  end
  task ack_ev(input int k, input logic [3:0] c);
    @(posedge clk_i);
    ack_code_o <= c;
    {ack_short_o, ack_long_o, ack_timeout_o, ack_normal_o} <= 4'h1 << k;
    @(posedge clk_i);
    {ack_short_o, ack_long_o, ack_timeout_o, ack_normal_o} <= 4'h0;
    // Code is not held past the event, so scramble it
    ack_code_o <= ~c;
  endtask : ack_ev
  task rx_pkt(input logic wl, input logic room);
    @(posedge clk_i);
    rx_ackable_o <= 1'b1;
    rx_wl_o <= wl;
    rx_room_o <= room;
    @(posedge clk_i);
    rx_ackable_o <= 1'b0;
    rx_wl_o <= ~wl;
    rx_room_o <= ~room;
  endtask : rx_pkt
endmodule : lar_link_model

//--- bench/tb_link_ack_status_and_control_regs.sv
// Self-checking bench for the ack status and link control registers
`timescale 1ns/1ps
module tb_link_ack_status_and_control_regs;
  import lar_pkg::*;
  logic ref_clk_i = 0, sys_rst_i = 1, soft_rst_i = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d, v;
  logic [3:0] wstrb = 0, c;
  logic [1:0] r, b;
  logic awready, wready, bvalid, arready, rvalid, an, at, al, as, ra, wl, rm;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] ac, rx_code;
  logic tx_arb = 0, far = 0, pin, go, txe, txr, sid, rxr, rx_stb, ctdr, oe_n;
  int seed = 32'hdf3d01ac, err_count = 0, checks_done = 0, txr_n, rxr_n, i;
  always #12.5 ref_clk_i = ~ref_clk_i;
  lar_regs u_lar_regs (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .soft_rst_i(soft_rst_i), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ack_normal_i(an), .ack_code_i(ac), .ack_timeout_i(at), .ack_long_i(al),
    .ack_short_i(as), .tx_arb_req_i(tx_arb), .tx_go_o(go),
    .transmitter_enable_o(txe), .transmitter_soft_reset_o(txr),
    .self_id_receive_enable_o(sid), .receiver_soft_reset_o(rxr),
    .rx_ackable_i(ra), .rx_write_lock_i(wl), .rx_fifo_room_i(rm),
    .rx_ack_strobe_o(rx_stb), .rx_ack_code_o(rx_code), .contender_i(pin),
    .contender_o(ctdr), .contender_oe_n_o(oe_n));
  lar_link_model u_lar_link_model (.clk_i(ref_clk_i), .ctdr_i(ctdr),
    .ctdr_oe_n_i(oe_n), .far_ctdr_i(far), .pin_o(pin), .ack_normal_o(an),
    .ack_timeout_o(at), .ack_long_o(al), .ack_short_o(as), .ack_code_o(ac),
    .rx_ackable_o(ra), .rx_wl_o(wl), .rx_room_o(rm));
  // Soft reset pulses are counted, not sampled, so width errors show
  always @(posedge ref_clk_i) begin
    txr_n += (txr === 1'b1);
    rxr_n += (rxr === 1'b1);
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] dt);
    int n;
    logic ao, wo;
    @(posedge ref_clk_i);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= dt;
    wstrb <= 4'hf;
    {ao, wo, n} = 0;
    while (!(ao && wo) && n < 100) begin
      @(posedge ref_clk_i);
      n++;
      if (awready && !ao) begin
        ao = 1;
        awvalid <= 0;
      end
      if (wready && !wo) begin
        wo = 1;
        wvalid <= 0;
      end
    end
    bready <= 1;
    do begin @(posedge ref_clk_i); n++; end while (!bvalid && n < 200);
    b = bresp;
    bready <= 0;
    if (n >= 200) chk("write wait", 0, 1);
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
    int n;
    @(posedge ref_clk_i);
    arvalid <= 1;
    araddr <= a;
    n = 0;
    do begin @(posedge ref_clk_i); n++; end while (!arready && n < 100);
    arvalid <= 0;
    rready <= 1;
    do begin @(posedge ref_clk_i); n++; end while (!rvalid && n < 200);
    dt = rdata;
    rs = rresp;
    rready <= 0;
    if (n >= 200) chk("read wait", 0, 1);
  endtask : rd
  function automatic logic [31:0] ack_exp(int k, logic [3:0] cd);
    logic [31:0] e = 32'h8000_0000;
    case (k)
      0: e[27:23] = {cd, 1'b0};
      1: e[27:23] = {LAR_EXT_TIMEOUT, 1'b1};
      2: e[27:23] = {LAR_EXT_LONG, 1'b1};
      default: e[27:23] = {LAR_EXT_SHORT, 1'b1};
    endcase
    return e;
  endfunction : ack_exp
  function automatic logic [3:0] rx_exp(logic b, logic m, logic w, logic p);
    if (b || !m) return LAR_ACK_BUSY_X;
    return (w && !p) ? LAR_ACK_COMPLETE : LAR_ACK_PENDING;
  endfunction : rx_exp
  task results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  initial begin
    #(25 * 20000);
    err_count++;
    results;
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    rd(LAR_BULK_ACK_OFF, d, r);
    chk("ack reset", d, 32'h0);
    rd(LAR_LINK_CTRL_OFF, d, r);
    chk("ctrl reset", d, LAR_LINK_CONTROL_RST);
    chk("oe_n reset", oe_n, 1'b1);
    rd(8'h04, d, r);
    chk("unmapped", {r, d[29:0]}, {LAR_RESP_SLVERR, 30'h0});
    wr(8'h04, 32'hffff_ffff);
    chk("bresp unmapped", b, LAR_RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      c = (i == 4) ? 4'hf : 4'($random(seed));
      u_lar_link_model.ack_ev(i % 4, c);
      rd(LAR_BULK_ACK_OFF, d, r);
      chk("ack", d, ack_exp(i%4, c));
      rd(LAR_BULK_ACK_OFF, d, r);
      chk("ack clear", d, ack_exp(i % 4, c) & 32'h7fff_ffff);
    end
    wr(LAR_BULK_ACK_OFF, 32'hffff_ffff);
    chk("bresp mapped", b, LAR_RESP_OKAY);
    rd(LAR_BULK_ACK_OFF, d, r);
    chk("ack locked", d, ack_exp(3, c) & 32'h7fff_ffff);
    wr(LAR_DIAGNOSTIC_TEST_REGISTER_OFF, 32'h1);
    wr(LAR_BULK_ACK_OFF, 32'hffff_ffff);
    rd(LAR_BULK_ACK_OFF, d, r);
    chk("ack write", d, 32'h8f80_0000);
    wr(LAR_DIAGNOSTIC_TEST_REGISTER_OFF, 32'h0);
    tx_arb <= 1;
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      v[11:10] = 2'h0;
      {v[2], v[13]} = 2'(i);
      far <= v[31];
      wr(LAR_LINK_CTRL_OFF, v);
      rd(LAR_LINK_CTRL_OFF, d, r);
      chk("ctrl", d, v & 32'h0000_2067);
      chk("tx pins", {go, txe}, {v[0], v[0]});
      chk("selfid pin", sid, v[1]);
      chk("ctdr pins", {oe_n, ctdr}, v[6:5]);
      rd(LAR_DIAGNOSTIC_TEST_REGISTER_OFF, d, r);
      chk("pin", d[1], v[6] ? v[31] : v[5]);
      u_lar_link_model.rx_pkt(i[2], i[3]);
      @(negedge ref_clk_i);
      c = rx_exp(v[2], i[3], i[2], v[13]);
      chk("rx stb", rx_stb, 1'b1);
      chk("rx code", rx_code, c);
    end
    {txr_n, rxr_n} = 0;
    wr(LAR_LINK_CTRL_OFF, 32'h0000_0c01);
    repeat (4) @(posedge ref_clk_i);
    chk("soft pulses", {txr_n[3:0], rxr_n[3:0]}, 8'h11);
    rd(LAR_LINK_CTRL_OFF, d, r);
    chk("self clear", d, 32'h1);
    u_lar_link_model.ack_ev(0, 4'h5);
    @(posedge ref_clk_i);
    soft_rst_i <= 1;
    @(posedge ref_clk_i);
    soft_rst_i <= 0;
    rd(LAR_LINK_CTRL_OFF, d, r);
    chk("ctrl soft reset", d, LAR_LINK_CONTROL_RST);
    rd(LAR_BULK_ACK_OFF, d, r);
    chk("ack soft reset", d, 32'h0);
    results;
  end
endmodule : tb_link_ack_status_and_control_regs
